// file: scwg_bus_master.sv
// Purpose: Two-wire bus master model driving the config guard
// Assumes: SDA has a pull-up; SCL period 48 ns, held high between frames
// Notes:   Data changes mid low phase; SDA is sampled at the SCL rise
`timescale 1ns/100ps
module scwg_bus_master (
    output logic sclClk,
    output logic mSda,
    input wire logic sdaWire
);
    initial begin
        sclClk = 1'h1;
        mSda = 1'h1;
    end
    task automatic bitx(input logic b, output logic got);
        #12 mSda = b;
        #12 sclClk = 1'h1;
        got = sdaWire;
        #24 sclClk = 1'h0;
    endtask
    // Also serves as repeated start after an acknowledge bit
    task automatic start();
        #12 mSda = 1'h1;
        #12 sclClk = 1'h1;
        #12 mSda = 1'h0;
        #12 sclClk = 1'h0;
    endtask
    task automatic stop();
        #12 mSda = 1'h0;
        #12 sclClk = 1'h1;
        #12 mSda = 1'h1;
        #12;
    endtask
    // MSB first; ack is 1 when the device pulled SDA low in bit nine
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], g);
        end
        bitx(1'h1, g);
        ack = !g;
    endtask
    // One byte only, then NACK; the device ignores the bus after the ninth bit until STOP
    task automatic rbyte(output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'h1, g);
            d[i] = g;
        end
        bitx(1'h1, g);
    endtask
endmodule // scwg_bus_master

// file: scwg_config_guard.sv
// Purpose: Control/status register, write guard and reset delay of a supervisor
// Assumes: Bus clock arrives on sclClk; pins are synchronised before use
// Notes:   Nonvolatile bits are restored from nvRestore after reset release

`timescale 1ns/100ps

// Function
// R1: Partition select 00 locks nothing, 01 C0h-FFh, 10 80h-FFh, 11 everything.
// R2: A write into the locked partition is aborted, array left untouched.
// R3: Any nonzero partition select refuses every wiper write.
// R4: Write-protect pin high inhibits nonvolatile array and wiper writes.
// R5: Delay select 00/01/10/11 gives 50/100/200/300 ms reset delay.
// R6: Reset output stays high until supply good for the selected delay.
// R7: Partition and delay selects come up holding their last stored values.
// R8: Monitor flags are volatile, read 0 after power-up, settable by a write.
// R9: A flag can be set only while its monitor fail output is high.
// R10: A set flag clears when its fail output goes low or on power cycle.
// R11: Register addressed by device address 1010010 and address byte FFh.
// R12: One data byte per write; a second byte is refused and aborts.
// R13: STOP after the data byte starts the 5 ms nonvolatile store.
// R14: Master writes 02h then 06h in separate frames before configuring.
// R15: Config byte: delay hi, two flags, partition hi/lo, 0, 1, delay lo.
// R16: The nonvolatile store clears the register-write latch.
// R17: Bit 2 set in the third write only sets the register-write latch.
// R18: Write-protect high ignores nonvolatile bits; volatile bits stay writable.
// R19: Read uses read byte 10100101 after address FFh; one byte then idle.
// R20: A register read leaves both latches and the write sequence intact.
// R21: Any write needs the global latch; config writes also need the other.
// R22: A store starts only after correct clock count and bit sequence.
// R23: With global latch clear a write aborts and the data byte is not acked.
// R24: Register-write latch clears after a config write or a locked array write.
// R25: Global latch resets clear, set by writing 02h, cleared by a write.
// R26: Reset delay counter restarts when supply good drops, releases at count.
// R27: During a store the device ignores the bus and does not ack.
module scwg_config_guard
    import scwg_pkg::*;
#(
    parameter int RST_DLY_50_CYC = DLY_50_MS * CLK_KHZ,
    parameter int RST_DLY_100_CYC = DLY_100_MS * CLK_KHZ,
    parameter int RST_DLY_200_CYC = DLY_200_MS * CLK_KHZ,
    parameter int RST_DLY_300_CYC = DLY_300_MS * CLK_KHZ,
    parameter int STORE_CYC = STORE_MS * CLK_KHZ
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic wpPin,
    input wire logic monitor2FailOut,
    input wire logic monitor3FailOut,
    input wire logic supplyGood,
    input wire logic [7:0] arrayAddr,
    input wire logic arrayWrTry,
    output logic arrayWrAllowed,
    output logic wiperVolWrAllowed,
    output logic wiperNvWrAllowed,
    output logic resetOut,
    input wire logic [3:0] nvRestore,
    output logic [3:0] nvImage,
    output logic nvBusy
);

    // ----------------------------------------------------------------
    // Link domain: one sample and one toggle per bus clock rise
    // ----------------------------------------------------------------
    logic linkSda_reg;
    logic linkTog_reg;

    always_ff @(posedge sclClk or negedge rst_n) begin
        if (!rst_n) begin
            linkSda_reg <= 1'h0;
            linkTog_reg <= 1'h0;
        end else begin
            linkSda_reg <= sdaIn;
            linkTog_reg <= ~linkTog_reg;
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [6:0] syncA_reg;
    logic [6:0] syncB_reg;
    logic sclS, sdaS, togS, wpS, mon2S, mon3S, supS;
    logic sclPrev_reg, sdaPrev_reg, togPrev_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA_reg <= 7'h0;
            syncB_reg <= 7'h0;
            sclPrev_reg <= 1'h0;
            sdaPrev_reg <= 1'h0;
            togPrev_reg <= 1'h0;
        end else begin
            syncA_reg <= {sclClk, sdaIn, linkTog_reg, wpPin,
                          monitor2FailOut, monitor3FailOut, supplyGood};
            syncB_reg <= syncA_reg;
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
            togPrev_reg <= togS;
        end
    end

    assign {sclS, sdaS, togS, wpS, mon2S, mon3S, supS} = syncB_reg;

    logic startEv, stopEv, sclFall, bitEv;
    assign startEv = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
    assign stopEv = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
    assign sclFall = sclPrev_reg && !sclS;
    // The sample settles at the bus clock rise, two synchroniser stages before its toggle shows
    assign bitEv = togS != togPrev_reg;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic globalWriteLatchReg, configWriteLatchReg;
    logic monitor2FailFlagReg, monitor3FailFlagReg;
    logic [1:0] partSelReg, resetDelaySelReg;
    logic loaded_reg;
    logic [CNT_W-1:0] storeCnt_reg, porCnt_reg;
    logic [7:0] ctrlByte;

    assign ctrlByte = {resetDelaySelReg[1], monitor2FailFlagReg, monitor3FailFlagReg,
                       partSelReg, configWriteLatchReg, globalWriteLatchReg,
                       resetDelaySelReg[0]};
    assign nvBusy = storeCnt_reg != '0;

    // ----------------------------------------------------------------
    // Bus engine
    // ----------------------------------------------------------------
    scwg_state_t st_reg, st_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
    logic [7:0] data_reg, data_next;
    logic ackPend_reg, ackPend_next, oe_reg, oe_next;
    logic ptr_reg, ptr_next, valid_reg, valid_next;
    logic [7:0] shiftIn;
    logic active, byteDone, ackDone, dataAccept;

    assign shiftIn = {shift_reg[SH_TOP:0], linkSda_reg};
    assign active = (st_reg != ST_IDLE) && (st_reg != ST_IGNORE);
    assign byteDone = bitEv && active && (bitCnt_reg == LAST_BIT);
    assign ackDone = bitEv && active && (bitCnt_reg == ACK_BIT);
    assign dataAccept = globalWriteLatchReg || (shiftIn == CMD_GLOBAL_LATCH); // [R23]

    always_comb begin
        st_next = st_reg;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        data_next = data_reg;
        ackPend_next = ackPend_reg;
        oe_next = oe_reg;
        ptr_next = ptr_reg;
        valid_next = valid_reg;
        if (startEv) begin
            st_next = ST_DEV;
            bitCnt_next = BIT_ZERO;
            ackPend_next = 1'h0;
            oe_next = 1'h0;
            valid_next = 1'h0;
        end else if (stopEv) begin
            st_next = ST_IDLE;
            ackPend_next = 1'h0;
            oe_next = 1'h0;
            valid_next = 1'h0;
        end else begin
            if (bitEv && active) begin
                shift_next = shiftIn;
                bitCnt_next = ackDone ? BIT_ZERO : bitCnt_reg + BIT_ONE;
            end
            if (ackDone && st_reg == ST_RSTART)
                st_next = ST_RDATA;
            else if (ackDone && st_reg == ST_RDATA)
                st_next = ST_IGNORE; // [R19]
            if (byteDone) begin
                case (st_reg)
                    ST_DEV: begin
                        if (nvBusy) begin
                            st_next = ST_IGNORE; // [R27]
                        end else if (shiftIn == DEV_WR_BYTE) begin
                            ackPend_next = 1'h1; // [R11]
                            st_next = ST_REG;
                        end else if (shiftIn == DEV_RD_BYTE && ptr_reg) begin
                            ackPend_next = 1'h1; // [R19]
                            tx_next = ctrlByte; // [R20]
                            st_next = ST_RSTART;
                        end else begin
                            st_next = ST_IGNORE;
                        end
                    end
                    ST_REG: begin
                        ptr_next = shiftIn == CTRL_STATUS_OFS; // [R11]
                        ackPend_next = shiftIn == CTRL_STATUS_OFS;
                        st_next = (shiftIn == CTRL_STATUS_OFS) ? ST_WDATA : ST_IGNORE;
                    end
                    ST_WDATA: begin
                        ackPend_next = dataAccept; // [R23]
                        valid_next = dataAccept;
                        data_next = shiftIn;
                        st_next = dataAccept ? ST_WDONE : ST_IGNORE;
                    end
                    ST_WDONE: begin
                        valid_next = 1'h0; // [R12]
                        st_next = ST_IGNORE;
                    end
                    default: begin
                        st_next = st_reg;
                    end
                endcase
            end
            if (sclFall) begin
                if (ackPend_reg) begin
                    oe_next = 1'h1;
                    ackPend_next = 1'h0;
                end else if (st_reg == ST_RDATA && bitCnt_reg != ACK_BIT) begin
                    oe_next = !tx_reg[MSB_POS];
                    tx_next = tx_reg << 1;
                end else begin
                    oe_next = 1'h0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            bitCnt_reg <= BIT_ZERO;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            data_reg <= 8'h00;
            ackPend_reg <= 1'h0;
            oe_reg <= 1'h0;
            ptr_reg <= 1'h0;
            valid_reg <= 1'h0;
        end else begin
            st_reg <= st_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            data_reg <= data_next;
            ackPend_reg <= ackPend_next;
            oe_reg <= oe_next;
            ptr_reg <= ptr_next;
            valid_reg <= valid_next;
        end
    end

    assign sdaOut = 1'h0;
    assign sdaOe = oe_reg;

    // ----------------------------------------------------------------
    // Commit decode at STOP
    // ----------------------------------------------------------------
    logic commit, cfgWr, cfgLatchSet, glbSet, glbClr, nvStart, lockHit;
    // A full byte plus its ack clock counts; the STOP's own SCL rise adds one bit
    assign commit = stopEv && st_reg == ST_WDONE && valid_reg
                    && (bitCnt_reg == BIT_ZERO || bitCnt_reg == BIT_ONE); // [R22]
    assign cfgWr = commit && globalWriteLatchReg && configWriteLatchReg
                   && data_reg[POS_GLB_LATCH] && !data_reg[POS_CFG_LATCH]; // [R21]
    assign cfgLatchSet = commit && globalWriteLatchReg && (data_reg == CMD_BOTH_LATCH
                         || (configWriteLatchReg && data_reg[POS_CFG_LATCH]
                         && data_reg[POS_GLB_LATCH])); // [R17]
    assign glbSet = commit && data_reg == CMD_GLOBAL_LATCH; // [R25]
    assign glbClr = commit && data_reg == CMD_CLEAR;
    assign nvStart = cfgWr && !wpS; // [R18]
    assign lockHit = arrayWrTry && scwg_locked(partSelReg, arrayAddr);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            globalWriteLatchReg <= 1'h0;
            configWriteLatchReg <= 1'h0;
            monitor2FailFlagReg <= 1'h0; // [R8]
            monitor3FailFlagReg <= 1'h0;
        end else begin
            globalWriteLatchReg <= glbClr ? 1'h0 : (glbSet || globalWriteLatchReg); // [R25]
            // A latch set in the same cycle as a clear wins
            configWriteLatchReg <= cfgLatchSet ? 1'h1
                : ((glbClr || cfgWr || lockHit) ? 1'h0 : configWriteLatchReg); // [R16] [R24]
            // A config write loads the written flag state; a low fail output always wins
            monitor2FailFlagReg <= mon2S && (cfgWr ? data_reg[POS_MON2]
                : monitor2FailFlagReg); // [R9] [R10]
            monitor3FailFlagReg <= mon3S && (cfgWr ? data_reg[POS_MON3]
                : monitor3FailFlagReg); // [R9] [R10]
        end
    end

    // ----------------------------------------------------------------
    // Nonvolatile selects and store timer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            partSelReg <= PART_RESET;
            resetDelaySelReg <= DLY_RESET;
            loaded_reg <= 1'h0;
            storeCnt_reg <= '0;
        end else begin
            loaded_reg <= 1'h1;
            if (!loaded_reg) begin
                {partSelReg, resetDelaySelReg} <= nvRestore; // [R7]
            end else if (nvStart) begin
                partSelReg <= {data_reg[POS_PART_HI], data_reg[POS_PART_LO]}; // [R15]
                resetDelaySelReg <= {data_reg[POS_DLY_HI], data_reg[POS_DLY_LO]};
            end
            if (nvStart)
                storeCnt_reg <= CNT_W'(STORE_CYC); // [R13]
            else if (nvBusy)
                storeCnt_reg <= storeCnt_reg - 1'b1;
        end
    end

    assign nvImage = {partSelReg, resetDelaySelReg};

    // ----------------------------------------------------------------
    // Power-on reset delay and write permissions
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] dlyTarget;
    assign dlyTarget = (resetDelaySelReg == DLY_50) ? CNT_W'(RST_DLY_50_CYC)
                     : (resetDelaySelReg == DLY_100) ? CNT_W'(RST_DLY_100_CYC)
                     : (resetDelaySelReg == DLY_200) ? CNT_W'(RST_DLY_200_CYC)
                     : CNT_W'(RST_DLY_300_CYC); // [R5]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            porCnt_reg <= '0;
            resetOut <= 1'h1;
            arrayWrAllowed <= 1'h0;
            wiperVolWrAllowed <= 1'h0;
            wiperNvWrAllowed <= 1'h0;
        end else begin
            porCnt_reg <= !supS ? '0
                : ((porCnt_reg < dlyTarget) ? porCnt_reg + 1'b1 : porCnt_reg); // [R26]
            resetOut <= !supS || (porCnt_reg < dlyTarget); // [R6]
            arrayWrAllowed <= globalWriteLatchReg && !wpS
                && !scwg_locked(partSelReg, arrayAddr); // [R1] [R2] [R4]
            wiperVolWrAllowed <= globalWriteLatchReg && partSelReg == PART_NONE; // [R3]
            wiperNvWrAllowed <= globalWriteLatchReg && partSelReg == PART_NONE
                && !wpS; // [R4]
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    latch_order_a: assert property (configWriteLatchReg |-> globalWriteLatchReg) // [R21]
        else $error("config latch set without global latch");
    lock_all_a: assert property (partSelReg == PART_ALL |=> !arrayWrAllowed) // [R1]
        else $error("array write allowed with full lock");
    wiper_lock_a: assert property (partSelReg != PART_NONE |=> !wiperVolWrAllowed) // [R3]
        else $error("wiper write allowed while locked");
    wp_inhibit_a: assert property (wpS |=> !arrayWrAllowed && !wiperNvWrAllowed) // [R4]
        else $error("nonvolatile write allowed under write protect");
    wp_nv_keep_a: assert property (loaded_reg && wpS && cfgWr |=> $stable(partSelReg) // [R18]
        && $stable(resetDelaySelReg) && !nvBusy)
        else $error("nonvolatile bits changed under write protect");
    flag_drop_a: assert property (!mon2S |=> !monitor2FailFlagReg) // [R10]
        else $error("monitor flag held with fail output low");
    reset_hold_a: assert property (!supS |=> resetOut [*2]) // [R6]
        else $error("reset released while supply not good");
    store_quiet_a: assert property (nvBusy |-> !sdaOe) // [R27]
        else $error("bus driven during store");
    store_start_a: assert property (nvStart |=> nvBusy && !configWriteLatchReg) // [R16]
        else $error("store did not start or latch not cleared");
    glb_set_a: assert property (glbSet && !glbClr |=> globalWriteLatchReg) // [R25]
        else $error("global latch not set by write");

    glb_set_c: cover property (glbSet);
    store_c: cover property (nvStart);
    read_c: cover property (ackDone && st_reg == ST_RDATA);

endmodule // scwg_config_guard

// file: scwg_pkg.sv
// Purpose: Shared constants and types for the supervisor config write guard
// Assumes: 250 MHz system clock; two-wire bus clock is a separate domain
// Notes:   Times are held in ms; cycle counts are derived in the top module

package scwg_pkg;

    // ----------------------------------------------------------------
    // Bus addressing
    // ----------------------------------------------------------------
    localparam logic [7:0] DEV_WR_BYTE = 8'hA4;
    localparam logic [7:0] DEV_RD_BYTE = 8'hA5;
    localparam logic [7:0] CTRL_STATUS_OFS = 8'hFF;

    // ----------------------------------------------------------------
    // Data byte commands and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_GLOBAL_LATCH = 8'h02;
    localparam logic [7:0] CMD_BOTH_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLEAR = 8'h00;
    localparam int POS_DLY_HI = 7;
    localparam int POS_MON2 = 6;
    localparam int POS_MON3 = 5;
    localparam int POS_PART_HI = 4;
    localparam int POS_PART_LO = 3;
    localparam int POS_CFG_LATCH = 2;
    localparam int POS_GLB_LATCH = 1;
    localparam int POS_DLY_LO = 0;
    localparam int MSB_POS = 7;
    localparam int SH_TOP = 6;

    // ----------------------------------------------------------------
    // Partition select and reset delay encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] PART_NONE = 2'h0;
    localparam logic [1:0] PART_QTR = 2'h1;
    localparam logic [1:0] PART_HALF = 2'h2;
    localparam logic [1:0] PART_ALL = 2'h3;
    localparam logic [7:0] QTR_BASE = 8'hC0;
    localparam logic [7:0] HALF_BASE = 8'h80;
    localparam logic [1:0] DLY_50 = 2'h0;
    localparam logic [1:0] DLY_100 = 2'h1;
    localparam logic [1:0] DLY_200 = 2'h2;
    localparam logic [1:0] PART_RESET = PART_NONE;
    localparam logic [1:0] DLY_RESET = DLY_100;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 250000;
    localparam int DLY_50_MS = 50;
    localparam int DLY_100_MS = 100;
    localparam int DLY_200_MS = 200;
    localparam int DLY_300_MS = 300;
    localparam int STORE_MS = 5;
    localparam int CNT_W = 27;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum {ST_IDLE, ST_DEV, ST_REG, ST_WDATA, ST_WDONE,
                  ST_RSTART, ST_RDATA, ST_IGNORE} scwg_state_t;

    // True when the array address lies in the locked partition
    function automatic logic scwg_locked(input logic [1:0] sel,
                                         input logic [7:0] addr);
        case (sel)
            PART_QTR: scwg_locked = (addr >= QTR_BASE);
            PART_HALF: scwg_locked = (addr >= HALF_BASE);
            PART_ALL: scwg_locked = 1'h1;
            default: scwg_locked = 1'h0;
        endcase
    endfunction

endpackage

// file: testbench.sv
// Purpose: Self-checking bench for the supervisor config write guard
// Assumes: Shortened store and reset-delay counts; SDA pulled up
// Notes:   Table rows walk the enable sequence; edge cases follow
`timescale 1ns/100ps
module testbench
    import scwg_pkg::*;
;
    typedef struct packed {
        logic [7:0] d;
        logic ack;
        logic [7:0] rd;
        logic [3:0] nv;
    } scwg_row_t;
    scwg_row_t rows [8] = '{'{8'h06, 1'h0, 8'h00, 4'h0}, '{8'h02, 1'h1, 8'h02, 4'h0},
        '{8'h06, 1'h1, 8'h06, 4'h0}, '{8'h9E, 1'h1, 8'h06, 4'h0}, '{8'hFB, 1'h1, 8'hDB, 4'hF},
        '{8'h06, 1'h1, 8'hDF, 4'hF}, '{8'h0A, 1'h1, 8'h0A, 4'h4}, '{8'h00, 1'h1, 8'h08, 4'h4}};
    logic clock = 1'h0;
    logic rst_n, sclClk, mSda, sdaWire, sdaOut, sdaOe, wpPin, monitor2FailOut;
    logic monitor3FailOut, supplyGood, arrayWrTry, arrayWrAllowed, wiperVolWrAllowed;
    logic wiperNvWrAllowed, resetOut, nvBusy, a;
    logic [7:0] arrayAddr, r;
    logic [3:0] nvRestore, nvImage;
    int errors = 0;
    int checks = 0;
    always #2 clock = ~clock;
    assign sdaWire = (sdaOe ? sdaOut : 1'h1) & mSda;
    scwg_bus_master bm (.sclClk(sclClk), .mSda(mSda), .sdaWire(sdaWire));
    scwg_config_guard #(.RST_DLY_50_CYC(20), .RST_DLY_100_CYC(40), .RST_DLY_200_CYC(80),
        .RST_DLY_300_CYC(120), .STORE_CYC(400)) scwg_config_guard_inst (.clock(clock),
        .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .wpPin(wpPin), .monitor2FailOut(monitor2FailOut), .monitor3FailOut(monitor3FailOut),
        .supplyGood(supplyGood), .arrayAddr(arrayAddr), .arrayWrTry(arrayWrTry),
        .arrayWrAllowed(arrayWrAllowed), .wiperVolWrAllowed(wiperVolWrAllowed),
        .wiperNvWrAllowed(wiperNvWrAllowed), .resetOut(resetOut), .nvRestore(nvRestore),
        .nvImage(nvImage), .nvBusy(nvBusy));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic x;
        bm.start();
        bm.wbyte(DEV_WR_BYTE, x);
        chk("devAck", 8'h01, {7'h0, x});
        bm.wbyte(CTRL_STATUS_OFS, x);
        bm.wbyte(d, ack);
        bm.stop();
    endtask
    // Waits out any store first, since the device ignores the bus meanwhile
    task automatic rd(output logic [7:0] d);
        logic x;
        int n;
        n = 0;
        repeat (8) @(posedge clock);
        while (nvBusy !== 1'h0 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        bm.start();
        bm.wbyte(DEV_WR_BYTE, x);
        bm.wbyte(CTRL_STATUS_OFS, x);
        bm.start();
        bm.wbyte(DEV_RD_BYTE, x);
        bm.rbyte(d);
        bm.stop();
    endtask
    task automatic dly(input int c);
        int n;
        n = 0;
        @(posedge clock) supplyGood <= 1'h0;
        repeat (6) @(posedge clock);
        supplyGood <= 1'h1;
        while (resetOut !== 1'h0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk("resetDelay", 8'h01, {7'h0, (n >= c && n <= c + 6)});
    endtask
    task automatic settle(input logic [7:0] ad, input logic w);
        @(posedge clock) arrayAddr <= ad;
        wpPin <= w;
        repeat (5) @(posedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'h0;
        wpPin = 1'h0;
        monitor2FailOut = 1'h0;
        monitor3FailOut = 1'h0;
        supplyGood = 1'h0;
        arrayAddr = 8'h00;
        arrayWrTry = 1'h0;
        nvRestore = 4'h0;
        repeat (8) @(posedge clock);
        chk("resetOutRst", 8'h01, {7'h0, resetOut});
        rst_n <= 1'h1;
        monitor2FailOut <= 1'h1;
        dly(20);
        foreach (rows[i]) begin
            wr(rows[i].d, a);
            chk("dataAck", {7'h0, rows[i].ack}, {7'h0, a});
            rd(r);
            chk("regRead", rows[i].rd, r);
            chk("nvImage", {4'h0, rows[i].nv}, {4'h0, nvImage});
        end
        $display("table test done");
        wr(CMD_GLOBAL_LATCH, a);
        settle(8'hBF, 1'h0);
        chk("allowBelow", 8'h01, {7'h0, arrayWrAllowed});
        settle(8'hC0, 1'h0);
        chk("allowLocked", 8'h00, {7'h0, arrayWrAllowed});
        chk("wiperVol", 8'h00, {7'h0, wiperVolWrAllowed});
        settle(8'h00, 1'h1);
        chk("allowWp", 8'h00, {7'h0, arrayWrAllowed});
        chk("wiperNv", 8'h00, {7'h0, wiperNvWrAllowed});
        settle(8'hC0, 1'h0);
        $display("permission test done");
        wr(CMD_BOTH_LATCH, a);
        rd(r);
        chk("readKeeps", 8'h0E, r);
        @(posedge clock) arrayWrTry <= 1'h1;
        @(posedge clock) arrayWrTry <= 1'h0;
        rd(r);
        chk("lockedTry", 8'h0A, r);
        wr(CMD_BOTH_LATCH, a);
        settle(8'hC0, 1'h1);
        wr(8'h5A, a);
        rd(r);
        chk("wpWrite", 8'h4A, r);
        chk("wpNvImage", 8'h04, {4'h0, nvImage});
        @(posedge clock) monitor2FailOut <= 1'h0;
        settle(8'hC0, 1'h0);
        rd(r);
        chk("flagClear", 8'h0A, r);
        $display("latch test done");
        bm.start();
        bm.wbyte(DEV_WR_BYTE, a);
        bm.wbyte(8'hFE, a);
        bm.stop();
        chk("badOffset", 8'h00, {7'h0, a});
        bm.start();
        bm.wbyte(DEV_WR_BYTE, a);
        bm.wbyte(CTRL_STATUS_OFS, a);
        bm.wbyte(CMD_CLEAR, a);
        bm.wbyte(CMD_CLEAR, a);
        bm.stop();
        chk("secondByte", 8'h00, {7'h0, a});
        rd(r);
        chk("abortKeeps", 8'h0A, r);
        wr(CMD_BOTH_LATCH, a);
        wr(8'h12, a);
        bm.start();
        bm.wbyte(DEV_WR_BYTE, a);
        bm.stop();
        chk("busyAck", 8'h00, {7'h0, a});
        chk("busyFlag", 8'h01, {7'h0, nvBusy});
        rd(r);
        chk("afterStore", 8'h12, r);
        $display("bus test done");
        @(posedge clock) rst_n <= 1'h0;
        nvRestore <= 4'h6;
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;
        dly(80);
        chk("restore", 8'h06, {4'h0, nvImage});
        rd(r);
        chk("powerUp", 8'h88, r);
        $display("reset test done");
        report_and_stop();
    end
endmodule // testbench
